/* File: src/qup_consts.vh */
// Constants for the quad UART pin and status logic.
// Assumes a 100 MHz system clock and a 68-style strobed register bus.
// How it works
// - A one in modem_control_reg bit 1 drives that channel's rtsN low.
// - After reset every rtsN is high until software writes it.
// - A held character forces rtsN high only with enhanced_feature_reg bit 6 set.
// - readNotWrite high reads, low writes the addressed register.
// - Each serialOut is high in reset, when idle and in loop-back.
// - Loop-back ignores serialIn and feeds transmit data to receive.
// - rxReadySummaryN is low while any channel holds a character.
// - rxReadySummaryN returns high once no character is held.
// - txReadySummaryN is low while any channel has a free slot.
// - txReadySummaryN is high only when no channel has a free slot.
// - Each channel's ready status reads back in its line status.
// - A high sys_rst resets all registers, outputs and both lines.
// - With chipSelN low, address lines 4..3 pick channel A to D.
`ifndef QUP_CONSTS_VH
`define QUP_CONSTS_VH
`define QUP_ADDR_HOLD      3'h0
`define QUP_ADDR_EFR       3'h2
`define QUP_ADDR_MCR       3'h4
`define QUP_ADDR_LSR       3'h5
`define QUP_MCR_RTS        1
`define QUP_MCR_LOOP       4
`define QUP_EFR_AUTORTS    6
`define QUP_LSR_RXREADY    0
`define QUP_LSR_OVERRUN    1
`define QUP_LSR_FRAMING    3
`define QUP_LSR_TXROOM     5
`define QUP_LSR_TXEMPTY    6
`define QUP_MCR_RESET      8'h00
`define QUP_EFR_RESET      8'h00
`define QUP_CLK_HZ         100000000
`define QUP_BAUD           115200
`define QUP_OVERSAMPLE     16
`define QUP_SAMPLE_MID     4'h7
`define QUP_SAMPLE_LAST    4'hf
`define QUP_LAST_BIT       4'h9
`endif

/* File: src/qup_buf.v */
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module qup_buf #(
    parameter WIDTH = 8
) (
    input  wire             clk,
    input  wire             sys_rst,
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData,
    output wire             isEmpty
);
    reg [WIDTH-1:0] head_r;
    reg [WIDTH-1:0] tail_r;
    reg [1:0]       count_r;
    wire            push;
    wire            pop;

    assign inReady  = (count_r != 2'd2);
    assign outValid = (count_r != 2'd0);
    assign outData  = head_r;
    assign isEmpty  = (count_r == 2'd0);
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;

    always @(posedge clk) begin
        if (sys_rst) begin
            count_r <= 2'd0;
            head_r  <= {WIDTH{1'b0}};
            tail_r  <= {WIDTH{1'b0}};
        end else begin
            case ({push, pop})
                2'b10: begin
                    if (count_r == 2'd0) begin
                        head_r <= inData;
                    end else begin
                        tail_r <= inData;
                    end
                    count_r <= count_r + 2'd1;
                end
                2'b01: begin
                    head_r  <= tail_r;
                    count_r <= count_r - 2'd1;
                end
                2'b11: begin
                    // Head leaves while a word arrives; keep order
                    if (count_r == 2'd1) begin
                        head_r <= inData;
                    end else begin
                        head_r <= tail_r;
                        tail_r <= inData;
                    end
                end
                default: begin
                    count_r <= count_r;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: src/qup_top.v */
// Four UART channels with modem, loop-back and shared ready pins.
// Assumes bus inputs synchronous to clk; one accessStb pulse per access.
`timescale 1ns/1ns
`default_nettype none
`include "qup_consts.vh"
module qup_top #(
    parameter CLK_HZ = `QUP_CLK_HZ,
    parameter BAUD   = `QUP_BAUD
) (
    input  wire       clk,
    input  wire       sys_rst,
    input  wire       accessStb,
    input  wire       chipSelN,
    input  wire       readNotWrite,
    input  wire [4:0] registerAddressLines,
    input  wire [7:0] writeData,
    output wire [7:0] readData,
    input  wire [3:0] serialIn,
    output wire [3:0] serialOut,
    output wire [3:0] rtsN,
    output wire       rxReadySummaryN,
    output wire       txReadySummaryN
);
    localparam integer DIV_RAW = CLK_HZ / (BAUD * `QUP_OVERSAMPLE);
    localparam integer DIV = (DIV_RAW < 1) ? 1 : DIV_RAW;
    // Counter is 16 bits; dividers above 65536 are not supported
    localparam integer DIV_M1 = DIV - 1;
    localparam [15:0]  DIV_LAST = DIV_M1[15:0];
    localparam [1:0] T_IDLE = 2'b01;
    localparam [1:0] T_SEND = 2'b10;
    localparam [1:0] R_IDLE = 2'b01;
    localparam [1:0] R_RECV = 2'b10;

    function chanHit;
        input       stb;
        input       csN;
        input [1:0] sel;
        input integer idx;
        begin
            chanHit = stb & ~csN & (sel == idx[1:0]);
        end
    endfunction

    // Register decode shared by every channel's read and write paths
    function regHit;
        input       acc;
        input [2:0] sel;
        input [2:0] addr;
        begin
            regHit = acc & (sel == addr);
        end
    endfunction

    reg  [15:0] divCnt_r;
    reg         tick_r;
    reg  [7:0]  readData_r;
    wire [31:0] mcrFlat;
    wire [31:0] efrFlat;
    wire [31:0] rxHoldFlat;
    wire [31:0] lsrFlat;
    wire [3:0]  rxValid;
    wire [3:0]  txRoom;
    wire [1:0]  chanSel;
    wire [2:0]  regSel;

    assign chanSel  = registerAddressLines[4:3];
    assign regSel   = registerAddressLines[2:0];
    assign readData = readData_r;
    assign rxReadySummaryN = ~|rxValid;
    assign txReadySummaryN = ~|txRoom;

    // One enable pulse at the oversampling rate serves all channels
    always @(posedge clk) begin
        if (sys_rst) begin
            divCnt_r <= 16'h0000;
            tick_r   <= 1'b0;
        end else if (divCnt_r == DIV_LAST) begin
            divCnt_r <= 16'h0000;
            tick_r   <= 1'b1;
        end else begin
            divCnt_r <= divCnt_r + 16'h0001;
            tick_r   <= 1'b0;
        end
    end

    // All channels share one tick, so they run at one rate
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : chan
            reg  [7:0] mcr_r;
            reg  [7:0] efr_r;
            reg  [7:0] rxHold_r;
            reg        rxFull_r;
            reg        overrun_r;
            reg        framing_r;
            reg        rts_r;
            reg  [1:0] txState_r;
            reg  [9:0] txShift_r;
            reg  [3:0] txCnt_r;
            reg  [3:0] txBit_r;
            reg  [1:0] rxState_r;
            reg  [7:0] rxShift_r;
            reg  [3:0] rxCnt_r;
            reg  [3:0] rxBit_r;
            wire       hit;
            wire       wr;
            wire       rd;
            wire       loop;
            wire       rxLine;
            wire       bufValid;
            wire       bufReady;
            wire [7:0] bufData;
            wire       bufEmpty;
            wire       rxDone;
            wire       rxPop;
            wire       lsrRead;

            assign hit  = chanHit(accessStb, chipSelN, chanSel, i);
            assign wr   = hit & ~readNotWrite;
            assign rd   = hit & readNotWrite;
            assign loop = mcr_r[`QUP_MCR_LOOP];
            // Loop-back replaces the pin with our own line
            assign rxLine = loop ? txShift_r[0] : serialIn[i];
            // Transmit line is forced high in loop-back
            assign serialOut[i] = txShift_r[0] | loop;
            assign rtsN[i] = ~rts_r;
            assign bufReady = (txState_r == T_IDLE);
            assign rxDone = tick_r & (rxState_r == R_RECV)
                          & (rxCnt_r == `QUP_SAMPLE_MID)
                          & (rxBit_r == `QUP_LAST_BIT);
            assign rxPop   = regHit(rd, regSel, `QUP_ADDR_HOLD);
            assign lsrRead = regHit(rd, regSel, `QUP_ADDR_LSR);

            assign mcrFlat[8*i+7:8*i]    = mcr_r;
            assign efrFlat[8*i+7:8*i]    = efr_r;
            assign rxHoldFlat[8*i+7:8*i] = rxHold_r;
            assign rxValid[i]            = rxFull_r;
            assign lsrFlat[8*i+7:8*i]    = {1'b0,
                bufEmpty & (txState_r == T_IDLE), txRoom[i], 1'b0,
                framing_r, 1'b0, overrun_r, rxFull_r};

            // Writes to a full holding buffer are dropped
            qup_buf #(
                .WIDTH(8)
            ) txBuf (
                .clk     (clk),
                .sys_rst (sys_rst),
                .inValid (regHit(wr, regSel, `QUP_ADDR_HOLD)),
                .inReady (txRoom[i]),
                .inData  (writeData),
                .outValid(bufValid),
                .outReady(bufReady),
                .outData (bufData),
                .isEmpty (bufEmpty)
            );

            always @(posedge clk) begin
                if (sys_rst) begin
                    mcr_r <= `QUP_MCR_RESET;
                    efr_r <= `QUP_EFR_RESET;
                    rts_r <= 1'b0;
                end else begin
                    if (regHit(wr, regSel, `QUP_ADDR_MCR)) begin
                        mcr_r <= writeData;
                    end
                    if (regHit(wr, regSel, `QUP_ADDR_EFR)) begin
                        efr_r <= writeData;
                    end
                    // Auto mode holds the partner off while a char waits
                    // The pin lags the register a clock, two after a write
                    if (efr_r[`QUP_EFR_AUTORTS]) begin
                        rts_r <= mcr_r[`QUP_MCR_RTS] & ~rxFull_r;
                    end else begin
                        rts_r <= mcr_r[`QUP_MCR_RTS];
                    end
                end
            end

            // Transmitter: start, eight data, stop; line rests high
            always @(posedge clk) begin
                if (sys_rst) begin
                    txState_r <= T_IDLE;
                    txShift_r <= 10'h3ff;
                    txCnt_r   <= 4'h0;
                    txBit_r   <= 4'h0;
                end else begin
                    case (txState_r)
                        T_IDLE: begin
                            if (bufValid) begin
                                txShift_r <= {1'b1, bufData, 1'b0};
                                txCnt_r   <= 4'h0;
                                txBit_r   <= 4'h0;
                                txState_r <= T_SEND;
                            end
                        end
                        T_SEND: begin
                            if (tick_r) begin
                                txCnt_r <= txCnt_r + 4'h1;
                                if (txCnt_r == `QUP_SAMPLE_LAST) begin
                                    txShift_r <= {1'b1, txShift_r[9:1]};
                                    txBit_r   <= txBit_r + 4'h1;
                                    if (txBit_r == `QUP_LAST_BIT) begin
                                        txState_r <= T_IDLE;
                                    end
                                end
                            end
                        end
                        default: begin
                            txState_r <= T_IDLE;
                        end
                    endcase
                end
            end

            // Receiver samples each bit near its middle
            always @(posedge clk) begin
                if (sys_rst) begin
                    rxState_r <= R_IDLE;
                    rxShift_r <= 8'h00;
                    rxCnt_r   <= 4'h0;
                    rxBit_r   <= 4'h0;
                end else begin
                    case (rxState_r)
                        R_IDLE: begin
                            if (tick_r & ~rxLine) begin
                                rxCnt_r   <= 4'h0;
                                rxBit_r   <= 4'h0;
                                rxState_r <= R_RECV;
                            end
                        end
                        R_RECV: begin
                            if (tick_r) begin
                                rxCnt_r <= rxCnt_r + 4'h1;
                                if (rxCnt_r == `QUP_SAMPLE_MID) begin
                                    rxBit_r <= rxBit_r + 4'h1;
                                    if (rxBit_r == 4'h0) begin
                                        // A short glitch is not a start
                                        if (rxLine) begin
                                            rxState_r <= R_IDLE;
                                        end
                                    end else if (rxBit_r == `QUP_LAST_BIT)
                                    begin
                                        rxState_r <= R_IDLE;
                                    end else begin
                                        rxShift_r <= {rxLine,
                                                      rxShift_r[7:1]};
                                    end
                                end
                            end
                        end
                        default: begin
                            rxState_r <= R_IDLE;
                        end
                    endcase
                end
            end

            // Holding register; a new char wins over a same-cycle read
            always @(posedge clk) begin
                if (sys_rst) begin
                    rxHold_r  <= 8'h00;
                    rxFull_r  <= 1'b0;
                    overrun_r <= 1'b0;
                    framing_r <= 1'b0;
                end else begin
                    if (rxDone) begin
                        rxHold_r <= rxShift_r;
                        rxFull_r <= 1'b1;
                    end else if (rxPop) begin
                        rxFull_r <= 1'b0;
                    end
                    // On overrun the newer character is kept, the older lost
                    if (rxDone & rxFull_r & ~rxPop) begin
                        overrun_r <= 1'b1;
                    end else if (lsrRead) begin
                        overrun_r <= 1'b0;
                    end
                    if (rxDone & ~rxLine) begin
                        framing_r <= 1'b1;
                    end else if (lsrRead) begin
                        framing_r <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Read data is captured on a selected read strobe and held until the next read
    always @(posedge clk) begin
        if (sys_rst) begin
            readData_r <= 8'h00;
        end else if (accessStb & ~chipSelN & readNotWrite) begin
            case (regSel)
                `QUP_ADDR_HOLD: readData_r <= rxHoldFlat[8*chanSel +: 8];
                `QUP_ADDR_EFR:  readData_r <= efrFlat[8*chanSel +: 8];
                `QUP_ADDR_MCR:  readData_r <= mcrFlat[8*chanSel +: 8];
                `QUP_ADDR_LSR: readData_r <= lsrFlat[8*chanSel +: 8];
                default:        readData_r <= 8'h00;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: bench/qup_top_sva.sv */
// Checker for the quad UART pin and status block, bound to qup_top.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
`include "qup_consts.vh"
module qup_top_sva (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       accessStb,
    input wire logic       chipSelN,
    input wire logic       readNotWrite,
    input wire logic [4:0] registerAddressLines,
    input wire logic [7:0] writeData,
    input wire logic [7:0] readData,
    input wire logic [3:0] serialOut,
    input wire logic [3:0] rtsN,
    input wire logic       rxReadySummaryN,
    input wire logic       txReadySummaryN
);
    logic [3:0] autoRts_r;
    logic [3:0] loop_r;
    logic [3:0] txUsed_r;
    wire        taken  = accessStb & ~chipSelN;
    wire [1:0]  ch     = registerAddressLines[4:3];
    wire [2:0]  regSel = registerAddressLines[2:0];
    wire        wrTk   = taken & ~readNotWrite;
    wire        rdTk   = taken & readNotWrite;
    wire        mcrWr  = wrTk & (regSel == `QUP_ADDR_MCR);
    wire        holdWr = wrTk & (regSel == `QUP_ADDR_HOLD);
    // Shadow of the bits whose effect the pins must show
    always @(posedge clk) begin
        if (sys_rst) begin
            autoRts_r <= 4'h0;
            loop_r    <= 4'h0;
            txUsed_r  <= 4'h0;
        end else begin
            if (mcrWr)
                loop_r[ch] <= writeData[`QUP_MCR_LOOP];
            if (wrTk & (regSel == `QUP_ADDR_EFR))
                autoRts_r[ch] <= writeData[`QUP_EFR_AUTORTS];
            if (holdWr)
                txUsed_r[ch] <= 1'b1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Reset levels are only meaningful while reset is applied
    chk_reset_levels: assert property (disable iff (1'b0)
        sys_rst ##1 sys_rst |-> rtsN == 4'hf && serialOut == 4'hf
        && readData == 8'h00 && rxReadySummaryN && !txReadySummaryN)
        else $error("outputs not at reset levels");
    chk_rts_write: assert property (mcrWr && !autoRts_r[ch] |->
        ##2 rtsN[$past(ch, 2)] == !$past(writeData[`QUP_MCR_RTS], 2))
        else $error("request-to-send does not follow control write");
    chk_rts_cause: assert property (autoRts_r == 4'h0
        && $past(autoRts_r, 2) == 4'h0
        && $changed(rtsN) |-> $past(mcrWr, 2))
        else $error("request-to-send moved without a control write");
    chk_loop_quiet: assert property (
        (loop_r & $past(loop_r) & ~serialOut) == 4'h0)
        else $error("transmit pin active during loop-back");
    chk_idle_high: assert property ((~txUsed_r & ~serialOut) == 4'h0)
        else $error("transmit pin low with nothing sent");
    chk_tx_full: assert property (txReadySummaryN |-> &txUsed_r)
        else $error("transmit summary high with an unused channel");
    chk_tx_rise: assert property ($rose(txReadySummaryN) |->
        $past(holdWr) || $past(holdWr, 2))
        else $error("transmit summary rose without a buffer write");
    chk_read_stand: assert property ($changed(readData) |->
        $past(rdTk) || $past(sys_rst))
        else $error("read data changed without a read");
    cover property (mcrWr && !rtsN[ch]);
    cover property (txReadySummaryN);
    cover property (!rxReadySummaryN);
    cover property (loop_r != 4'h0 && holdWr);
endmodule
bind qup_top qup_top_sva i_qup_top_sva (.clk(clk), .sys_rst(sys_rst),
    .accessStb(accessStb), .chipSelN(chipSelN), .readNotWrite(readNotWrite),
    .registerAddressLines(registerAddressLines), .writeData(writeData),
    .readData(readData), .serialOut(serialOut), .rtsN(rtsN),
    .rxReadySummaryN(rxReadySummaryN), .txReadySummaryN(txReadySummaryN));
`default_nettype wire

/* File: bench/qup_line_model.sv */
// Serial line partners of the four channels: 8N1, LSB first.
// Assumes one bit lasts BITCLK clocks and the bench calls the tasks.
`timescale 1ns/1ns
`default_nettype none
module qup_line_model #(
    parameter BITCLK = 16
) (
    input  wire logic       clk,
    input  wire logic [3:0] serialOut,
    output var  logic [3:0] serialIn
);
    // Lines rest at the idle mark level between frames
    initial serialIn = 4'hf;
    task automatic sendByte(input integer ch, input logic [7:0] b);
        logic [9:0] frame;
        integer     j;
        frame = {1'b1, b, 1'b0};
        for (j = 0; j < 10; j = j + 1) begin
            @(negedge clk);
            serialIn[ch] = frame[j];
            repeat (BITCLK - 1) @(negedge clk);
        end
    endtask
    // Bounded hunt for the start bit so a silent pin cannot hang the run
    task automatic recvByte(input integer ch, output logic [7:0] b);
        integer j;
        j = 0;
        while (serialOut[ch] !== 1'b0 && j < 1000) begin
            @(negedge clk);
            j = j + 1;
        end
        repeat (BITCLK / 2) @(negedge clk);
        for (j = 0; j < 8; j = j + 1) begin
            repeat (BITCLK) @(negedge clk);
            b[j] = serialOut[ch];
        end
    endtask
endmodule
`default_nettype wire

/* File: bench/qup_top_tb.sv */
// Testbench for qup_top with serial partners on all four channels.
// Assumes a divider of one, so a serial bit lasts 16 clocks.
`timescale 1ns/1ns
`default_nettype none
module qup_top_tb;
    logic        clk;
    logic        sys_rst;
    logic        accessStb;
    logic        chipSelN;
    logic        readNotWrite;
    logic [4:0]  regAddr;
    logic [7:0]  writeData;
    logic [7:0]  rxByte;
    logic [26:0] rows [0:11];
    wire  [7:0]  readData;
    wire  [3:0]  serialIn;
    wire  [3:0]  serialOut;
    wire  [3:0]  rtsN;
    wire         rxReadySummaryN;
    wire         txReadySummaryN;
    integer      miscompares;
    integer      n_compared;
    integer      i;
    integer      k;
    qup_top #(.CLK_HZ(1600), .BAUD(100)) i_qup_top (.clk(clk),
        .sys_rst(sys_rst), .accessStb(accessStb), .chipSelN(chipSelN),
        .readNotWrite(readNotWrite), .registerAddressLines(regAddr),
        .writeData(writeData), .readData(readData), .serialIn(serialIn),
        .serialOut(serialOut), .rtsN(rtsN),
        .rxReadySummaryN(rxReadySummaryN), .txReadySummaryN(txReadySummaryN));
    qup_line_model #(.BITCLK(16)) i_qup_line_model (.clk(clk),
        .serialOut(serialOut), .serialIn(serialIn));
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task acc(input logic cs, input logic rnw, input logic [4:0] a,
             input logic [7:0] d);
        @(negedge clk);
        accessStb    = 1'b1;
        chipSelN     = cs;
        readNotWrite = rnw;
        regAddr      = a;
        writeData    = d;
        @(negedge clk);
        accessStb    = 1'b0;
        chipSelN     = 1'b1;
    endtask
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Bounded wait on a summary pin reaching the given level
    task waitPin(input logic lvl, input logic rx);
        k = 0;
        while ((rx ? rxReadySummaryN : txReadySummaryN) !== lvl
               && k < 600) begin
            @(negedge clk);
            k = k + 1;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares = miscompares + 1;
        end_sim;
    end
    initial begin
        // Rows: chip select, read, address, write data, read data, rtsN
        rows[0]  = {1'h0, 1'h0, 5'h04, 8'h02, 8'h00, 4'he};
        rows[1]  = {1'h0, 1'h1, 5'h04, 8'h00, 8'h02, 4'he};
        rows[2]  = {1'h0, 1'h0, 5'h1c, 8'h02, 8'h00, 4'h6};
        rows[3]  = {1'h1, 1'h0, 5'h0c, 8'h02, 8'h00, 4'h6};
        rows[4]  = {1'h0, 1'h1, 5'h0c, 8'h00, 8'h00, 4'h6};
        rows[5]  = {1'h1, 1'h1, 5'h04, 8'h00, 8'h00, 4'h6};
        rows[6]  = {1'h0, 1'h0, 5'h12, 8'h40, 8'h00, 4'h6};
        rows[7]  = {1'h0, 1'h1, 5'h12, 8'h00, 8'h40, 4'h6};
        rows[8]  = {1'h0, 1'h0, 5'h01, 8'hff, 8'h00, 4'h6};
        rows[9]  = {1'h0, 1'h1, 5'h01, 8'h00, 8'h00, 4'h6};
        rows[10] = {1'h0, 1'h1, 5'h05, 8'h00, 8'h60, 4'h6};
        rows[11] = {1'h0, 1'h0, 5'h04, 8'h00, 8'h00, 4'h7};
        miscompares  = 0;
        n_compared   = 0;
        sys_rst      = 1'b1;
        accessStb    = 1'b0;
        chipSelN     = 1'b1;
        readNotWrite = 1'b1;
        regAddr      = 5'h00;
        writeData    = 8'h00;
        repeat (12) @(negedge clk);
        chk({4'h0, rtsN}, 8'h0f);
        chk({4'h0, serialOut}, 8'h0f);
        chk({6'h0, rxReadySummaryN, txReadySummaryN}, 8'h02);
        sys_rst = 1'b0;
        for (i = 0; i < 12; i = i + 1) begin
            acc(rows[i][26], rows[i][25], rows[i][24:20], rows[i][19:12]);
            repeat (2) @(negedge clk);
            if (rows[i][25])
                chk(readData, rows[i][11:4]);
            chk({4'h0, rtsN}, {4'h0, rows[i][3:0]});
        end
        acc(1'b0, 1'b0, 5'h08, 8'ha5);
        i_qup_line_model.recvByte(1, rxByte);
        chk(rxByte, 8'ha5);
        // Channel C has auto request-to-send on from the rows above
        acc(1'b0, 1'b0, 5'h14, 8'h02);
        repeat (2) @(negedge clk);
        chk({7'h0, rtsN[2]}, 8'h00);
        i_qup_line_model.sendByte(2, 8'h3c);
        chk({7'h0, rxReadySummaryN}, 8'h00);
        chk({7'h0, rtsN[2]}, 8'h01);
        acc(1'b0, 1'b1, 5'h15, 8'h00);
        @(negedge clk);
        chk(readData & 8'h01, 8'h01);
        acc(1'b0, 1'b1, 5'h10, 8'h00);
        @(negedge clk);
        chk(readData, 8'h3c);
        repeat (2) @(negedge clk);
        chk({7'h0, rxReadySummaryN}, 8'h01);
        chk({7'h0, rtsN[2]}, 8'h00);
        // A frame on the pin during loop-back must not reach the receiver
        acc(1'b0, 1'b0, 5'h04, 8'h10);
        fork
            i_qup_line_model.sendByte(0, 8'h00);
            acc(1'b0, 1'b0, 5'h00, 8'h5a);
        join
        waitPin(1'b0, 1'b1);
        acc(1'b0, 1'b1, 5'h00, 8'h00);
        @(negedge clk);
        chk(readData, 8'h5a);
        acc(1'b0, 1'b0, 5'h04, 8'h00);
        // Four writes per channel overfill a two-entry buffer
        for (i = 0; i < 16; i = i + 1)
            acc(1'b0, 1'b0, {i[1:0], 3'h0}, i[7:0]);
        @(negedge clk);
        chk({7'h0, txReadySummaryN}, 8'h01);
        acc(1'b0, 1'b1, 5'h1d, 8'h00);
        @(negedge clk);
        chk(readData & 8'h20, 8'h00);
        waitPin(1'b0, 1'b0);
        chk({7'h0, txReadySummaryN}, 8'h00);
        // Two characters with no read between them overrun channel D
        i_qup_line_model.sendByte(3, 8'h11);
        i_qup_line_model.sendByte(3, 8'h22);
        acc(1'b0, 1'b1, 5'h1d, 8'h00);
        @(negedge clk);
        chk(readData & 8'h03, 8'h03);
        acc(1'b0, 1'b1, 5'h1d, 8'h00);
        @(negedge clk);
        chk(readData & 8'h03, 8'h01);
        acc(1'b0, 1'b1, 5'h18, 8'h00);
        @(negedge clk);
        chk(readData, 8'h22);
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        chk({4'h0, rtsN}, 8'h0f);
        chk({4'h0, serialOut}, 8'h0f);
        chk(readData, 8'h00);
        end_sim;
    end
endmodule
`default_nettype wire
